// *** verilog/isb_pkg.sv ***
// constants and types for the i2c start, restart, baud and general call block
package isb_pkg;
  localparam int BRG_W = 7;
  localparam int BUF_W = 8;
  localparam int FIFO_DEPTH = 2;
  localparam logic [3:0] MODE_MASTER = 4'h8;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [4:0] TENBIT_HDR = 5'h1E;
  localparam logic [3:0] BIT_ADDR_DONE = 4'h8;
  localparam logic [3:0] BIT_ACK_DONE = 4'h9;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam int C2_START = 0;
  localparam int C2_RESTART = 1;
  localparam int C2_GENERAL_CALL_ENABLE = 7;
  localparam int C2_LOCK_LO = 5;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [BRG_W-1:0] BRG_ZERO = 7'h00;
  typedef enum logic [7:0] {
    M_IDLE       = 8'h01,
    M_ST_WAIT    = 8'h02,
    M_ST_HOLD    = 8'h04,
    M_RS_SCL_LO  = 8'h08,
    M_RS_SDA_HI  = 8'h10,
    M_RS_SCL_REL = 8'h20,
    M_RS_BOTH_HI = 8'h40,
    M_RS_SDA_LO  = 8'h80
  } isb_mstate_t;
endpackage : isb_pkg

// *** verilog/isb_core.sv ***
// i2c port: start/restart sequencer, baud generator, arbitration, general call
`timescale 1ns/1ps
module isb_core #(
  parameter int DEPTH = isb_pkg::FIFO_DEPTH,
  parameter int DW = isb_pkg::BUF_W
) (
  input wire logic mclk_i,                    // core clock
  input wire logic sys_rst_i,                 // sync reset, high
  input wire logic scl_i,                     // scl pin level
  output logic scl_o,                         // scl drive value
  output logic scl_oe_n_o,                    // scl drive enable, low
  input wire logic sda_i,                     // sda pin level
  output logic sda_o,                         // sda drive value
  output logic sda_oe_n_o,                    // sda drive enable, low
  input wire logic port_enable_i,             // port enable bit
  input wire logic [3:0] mode_select_i,       // mode select field
  input wire logic ten_bit_i,                 // slave ten-bit addressing
  input wire logic [7:0] address_baud_i,      // address/baud register
  input wire logic ctrl2_wr_i,                // second control write
  input wire logic [7:0] ctrl2_wdata_i,       // second control data
  output logic [7:0] ctrl2_o,                 // second control register
  input wire logic buf_wr_i,                  // buffer register write
  input wire logic [DW-1:0] buf_wdata_i,      // buffer write data
  input wire logic buf_rd_i,                  // buffer read, clears full
  output logic [DW-1:0] buffer_o,             // buffer register
  output logic buffer_full_o,                 // buffer full flag
  output logic update_address_o,              // update address flag
  input wire logic ua_clr_i,                  // clear update address
  input wire logic xfer_event_i,              // byte or ack done pulse
  output logic port_irq_o,                    // port interrupt flag
  input wire logic irq_clr_i,                 // clear interrupt flag
  output logic bus_coll_o,                    // bus collision flag
  input wire logic bcl_clr_i,                 // clear bus collision
  output logic write_coll_o,                  // write collision flag
  input wire logic write_collision_flag_clr_i,                // clear write collision
  output logic start_seen_o,                  // start seen status
  output logic stop_seen_o,                   // stop seen status
  output logic bus_free_o,                    // bus may be taken
  input wire logic sleep_i,                   // processor asleep
  input wire logic irq_enable_i,              // port interrupt enabled
  output logic wake_o,                        // wake pulse
  output logic [DW-1:0] rx_data_o,            // received byte
  output logic rx_valid_o,                    // received byte valid
  input wire logic rx_ready_i                 // consumer ready
);
  import isb_pkg::*;

  // pin synchronisers; the first stage is read only by the second
  logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
    end else begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  wire scl_rise = scl_s_r && !scl_d_r;
  wire scl_fall = !scl_s_r && scl_d_r;
  wire start_ev = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
  wire stop_ev = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;
  wire en_w = port_enable_i;
  wire master_w = en_w && (mode_select_i == MODE_MASTER);

  // bus condition status
  logic s_seen_r, p_seen_r;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !en_w) begin
      s_seen_r <= 1'b0;
      p_seen_r <= 1'b0;
    end else if (start_ev) begin
      s_seen_r <= 1'b1;
      p_seen_r <= 1'b0;
    end else if (stop_ev) begin
      s_seen_r <= 1'b0;
      p_seen_r <= 1'b1;
    end
  end
  assign start_seen_o = s_seen_r;
  assign stop_seen_o = p_seen_r;
  assign bus_free_o = p_seen_r || (!s_seen_r && !p_seen_r);

  // baud generator: one tick per two clocks, as the Q2/Q4 decrements
  logic [BRG_W-1:0] brg_cnt_r;
  logic brg_run_r, brg_ph_r;
  logic brg_load;
  wire [BRG_W-1:0] brg_reload = address_baud_i[BRG_W-1:0];
  wire brg_to = brg_run_r && brg_ph_r && (brg_cnt_r == BRG_ZERO);
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !en_w) begin
      brg_cnt_r <= BRG_ZERO;
      brg_run_r <= 1'b0;
      brg_ph_r <= 1'b0;
    end else if (brg_load) begin
      brg_cnt_r <= brg_reload;
      brg_run_r <= 1'b1;
      brg_ph_r <= 1'b0;
    end else if (brg_run_r) begin
      brg_ph_r <= !brg_ph_r;
      if (brg_ph_r) begin
        if (brg_cnt_r == BRG_ZERO) brg_run_r <= 1'b0;
        else brg_cnt_r <= brg_cnt_r - 7'h01;
      end
    end
  end

  // second control register
  logic [7:0] ctrl2_r;
  isb_mstate_t st_r, st_nxt;
  logic sda_drv_r, sda_drv_nxt, scl_drv_r, scl_drv_nxt;
  logic bcl_set, seq_done, clr_sen, clr_restart_request_bit;
  wire busy_w = (st_r != M_IDLE);
  // a set request bit already counts as in progress, before the state moves
  wire seq_pend = busy_w || (ctrl2_r[C2_RESTART:C2_START] != 2'b00);
  wire sen_go = master_w && ctrl2_r[C2_START];
  wire restart_request_bit_go = master_w && ctrl2_r[C2_RESTART] && !ctrl2_r[C2_START];
  // during a sequence, any released sda sampled low while scl high is a lost bit
  wire arb_lost = busy_w && scl_s_r && !sda_drv_r && !sda_s_r;
  wire abort_w = bcl_set || arb_lost;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctrl2_r <= CTRL2_RST;
    end else begin
      if (ctrl2_wr_i && seq_pend) begin
        ctrl2_r[7:C2_LOCK_LO] <= ctrl2_wdata_i[7:C2_LOCK_LO];
      end else if (ctrl2_wr_i) begin
        ctrl2_r <= ctrl2_wdata_i;
      end
      // clears last, so a write in the finishing cycle cannot revive a request
      if (clr_sen || abort_w || !en_w) ctrl2_r[C2_START] <= 1'b0;
      if (clr_restart_request_bit || abort_w || !en_w) ctrl2_r[C2_RESTART] <= 1'b0;
    end
  end
  assign ctrl2_o = ctrl2_r;

  // start / repeated start sequencer
  always_comb begin
    st_nxt = st_r;
    sda_drv_nxt = sda_drv_r;
    scl_drv_nxt = scl_drv_r;
    brg_load = 1'b0;
    bcl_set = 1'b0;
    seq_done = 1'b0;
    clr_sen = 1'b0;
    clr_restart_request_bit = 1'b0;
    case (st_r)
      M_IDLE: begin
        if (sen_go) begin
          if (!sda_s_r && !scl_s_r) begin
            bcl_set = 1'b1;
          end else if (sda_s_r && scl_s_r) begin
            brg_load = 1'b1;
            st_nxt = M_ST_WAIT;
          end
        end else if (restart_request_bit_go) begin
          scl_drv_nxt = 1'b1;
          st_nxt = M_RS_SCL_LO;
        end
      end
      M_ST_WAIT: begin
        if (!scl_s_r) begin
          bcl_set = 1'b1;
        end else if (brg_to) begin
          if (sda_s_r) begin
            sda_drv_nxt = 1'b1;
            brg_load = 1'b1;
            st_nxt = M_ST_HOLD;
          end else begin
            bcl_set = 1'b1;
          end
        end
      end
      M_ST_HOLD: begin
        if (brg_to) begin
          clr_sen = 1'b1;
          seq_done = 1'b1;
          st_nxt = M_IDLE;
        end
      end
      M_RS_SCL_LO: begin
        if (!scl_s_r) begin
          brg_load = 1'b1;
          sda_drv_nxt = 1'b0;
          st_nxt = M_RS_SDA_HI;
        end
      end
      M_RS_SDA_HI: begin
        if (brg_to) begin
          if (sda_s_r) begin
            scl_drv_nxt = 1'b0;
            st_nxt = M_RS_SCL_REL;
          end else begin
            bcl_set = 1'b1;
          end
        end
      end
      M_RS_SCL_REL: begin
        // reload waits for scl high, so a stretching slave holds us here
        if (scl_s_r) begin
          if (!sda_s_r) begin
            bcl_set = 1'b1;
          end else begin
            brg_load = 1'b1;
            st_nxt = M_RS_BOTH_HI;
          end
        end
      end
      M_RS_BOTH_HI: begin
        if (!scl_s_r) begin
          bcl_set = 1'b1;
        end else if (brg_to) begin
          sda_drv_nxt = 1'b1;
          brg_load = 1'b1;
          st_nxt = M_RS_SDA_LO;
        end
      end
      M_RS_SDA_LO: begin
        if (brg_to) begin
          clr_restart_request_bit = 1'b1;
          scl_drv_nxt = 1'b1;
          seq_done = 1'b1;
          st_nxt = M_IDLE;
        end
      end
      default: st_nxt = M_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !en_w || abort_w) begin
      st_r <= M_IDLE;
      sda_drv_r <= 1'b0;
      scl_drv_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sda_drv_r <= sda_drv_nxt;
      scl_drv_r <= scl_drv_nxt;
    end
  end

  // two-entry receive buffer, fed from the slave shift register
  logic [DW-1:0] sl_sr_r;
  logic [DW-1:0] fifo_mem [DEPTH];
  logic [$clog2(DEPTH)-1:0] wr_ptr_r, rd_ptr_r;
  logic [$clog2(DEPTH+1)-1:0] cnt_r;
  logic push;
  wire fifo_rdy = (cnt_r != DEPTH[$clog2(DEPTH+1)-1:0]);
  wire pop = rx_valid_o && rx_ready_i;
  assign rx_valid_o = (cnt_r != '0);
  assign rx_data_o = fifo_mem[rd_ptr_r];
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      for (int i = 0; i < DEPTH; i++) fifo_mem[i] <= BUF_RST;
    end else begin
      if (push) begin
        fifo_mem[wr_ptr_r] <= sl_sr_r;
        wr_ptr_r <= (wr_ptr_r == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) rd_ptr_r <= (rd_ptr_r == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      if (push && !pop) cnt_r <= cnt_r + 1'b1;
      else if (pop && !push) cnt_r <= cnt_r - 1'b1;
    end
  end

  // slave address recognition and byte receive
  logic [3:0] sl_bits_r;
  logic sl_act_r, sl_addr_r, sl_match_r, sl_ack_r, sl_stretch_r;
  wire gc_hit = ctrl2_r[C2_GENERAL_CALL_ENABLE] && (sl_sr_r == GC_ADDR);
  wire dev_hit = (sl_sr_r[7:1] == address_baud_i[7:1]);
  wire ten_hdr = ten_bit_i && (sl_sr_r[7:3] == TENBIT_HDR) && !sl_sr_r[0];
  wire hit_w = gc_hit || dev_hit || ten_hdr;
  wire byte8 = sl_act_r && ((scl_fall && sl_bits_r == BIT_ADDR_DONE) || sl_stretch_r);
  wire want_w = sl_addr_r ? hit_w : sl_match_r;
  wire ninth_fall = sl_act_r && scl_fall && (sl_bits_r == BIT_ACK_DONE);
  wire slave_en = en_w && !master_w;
  assign push = byte8 && want_w && fifo_rdy;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !slave_en || stop_ev) begin
      sl_sr_r <= BUF_RST;
      sl_bits_r <= BIT_ZERO;
      {sl_act_r, sl_addr_r, sl_match_r, sl_ack_r, sl_stretch_r} <= 5'h00;
    end else if (start_ev) begin
      sl_act_r <= 1'b1;
      sl_addr_r <= 1'b1;
      sl_match_r <= 1'b0;
      sl_bits_r <= BIT_ZERO;
      sl_ack_r <= 1'b0;
      sl_stretch_r <= 1'b0;
    end else if (sl_act_r) begin
      if (scl_rise) begin
        sl_bits_r <= sl_bits_r + 4'h1;
        if (sl_bits_r < BIT_ADDR_DONE) sl_sr_r <= {sl_sr_r[DW-2:0], sda_s_r};
      end
      if (byte8) begin
        if (!want_w) begin
          sl_act_r <= 1'b0;
        end else if (!fifo_rdy) begin
          sl_stretch_r <= 1'b1; // hold scl low until a slot frees
        end else begin
          sl_stretch_r <= 1'b0;
          sl_ack_r <= 1'b1;
          sl_match_r <= 1'b1;
        end
      end
      if (ninth_fall) begin
        sl_ack_r <= 1'b0;
        sl_bits_r <= BIT_ZERO;
        sl_addr_r <= 1'b0;
      end
    end
  end

  // buffer register, full, update address
  logic [DW-1:0] buf_r;
  logic bf_r, ua_r, write_collision_flag_r, bcl_r, irq_r, wake_r;
  wire wr_ok = buf_wr_i && !seq_pend;
  wire wr_refused = buf_wr_i && seq_pend;
  wire ua_set = push && sl_addr_r && ten_hdr && !gc_hit;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      buf_r <= BUF_RST;
      bf_r <= 1'b0;
      ua_r <= 1'b0;
    end else begin
      if (push) buf_r <= sl_sr_r;
      else if (wr_ok) buf_r <= buf_wdata_i;
      if (push || wr_ok) bf_r <= 1'b1;
      else if (buf_rd_i) bf_r <= 1'b0;
      if (ua_set) ua_r <= 1'b1;
      else if (ua_clr_i) ua_r <= 1'b0;
    end
  end

  // sticky flags: a set in the clearing cycle wins; wake is a one-cycle pulse
  wire stop_irq = master_w && stop_ev && s_seen_r;
  wire m_irq = master_w && (seq_done || xfer_event_i);
  wire s_irq = ninth_fall && sl_match_r;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      {write_collision_flag_r, bcl_r, irq_r, wake_r} <= 4'h0;
    end else begin
      if (wr_refused) write_collision_flag_r <= 1'b1;
      else if (write_collision_flag_clr_i) write_collision_flag_r <= 1'b0;
      if (abort_w) bcl_r <= 1'b1;
      else if (bcl_clr_i) bcl_r <= 1'b0;
      if (m_irq || stop_irq || s_irq) irq_r <= 1'b1;
      else if (irq_clr_i) irq_r <= 1'b0;
      wake_r <= s_irq && sleep_i && irq_enable_i;
    end
  end

  assign buffer_o = buf_r;
  assign buffer_full_o = bf_r;
  assign update_address_o = ua_r;
  assign write_coll_o = write_collision_flag_r;
  assign bus_coll_o = bcl_r;
  assign port_irq_o = irq_r;
  assign wake_o = wake_r;
  // open-drain: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n_o = !(scl_drv_r || sl_stretch_r);
  assign sda_oe_n_o = !(sda_drv_r || sl_ack_r);

endmodule : isb_core

// *** tb/isb_core_checker.sv ***
// concurrent checks on the ports of the start, restart and general call block
`timescale 1ns/1ps
module isb_core_checker
  import isb_pkg::*;
#(
  parameter int DW = BUF_W
) (
  input wire logic mclk_i, // clock
  input wire logic sys_rst_i, // reset
  input wire logic port_enable_i, // enable
  input wire logic [3:0] mode_select_i, // mode
  input wire logic ctrl2_wr_i, // control write
  input wire logic [7:0] ctrl2_wdata_i, // control data
  input wire logic [7:0] ctrl2_o, // control register
  input wire logic buf_wr_i, // buffer write
  input wire logic [DW-1:0] buffer_o, // buffer
  input wire logic xfer_event_i, // byte done
  input wire logic port_irq_o, // irq flag
  input wire logic bus_coll_o, // collision flag
  input wire logic write_coll_o, // write collision
  input wire logic start_seen_o, // start seen
  input wire logic stop_seen_o, // stop seen
  input wire logic bus_free_o, // bus free
  input wire logic scl_oe_n_o, // scl enable
  input wire logic sda_oe_n_o, // sda enable
  input wire logic sleep_i, // asleep
  input wire logic irq_enable_i, // irq enabled
  input wire logic wake_o // wake pulse
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // gated by enable: a disable may drop the request without any flag
  a_start_done: assert property ($fell(ctrl2_o[0]) && port_enable_i |-> port_irq_o || bus_coll_o)
    else $error("start request cleared with no flag");
  a_write_collision_flag_refused: assert property (buf_wr_i && ctrl2_o[1:0] != 2'b00 |=> write_coll_o && $stable(buffer_o))
    else $error("buffer written during sequence");
  a_low_bits_lock: assert property (ctrl2_wr_i && ctrl2_o[1:0] != 2'b00 |=>
    ctrl2_o[4:2] == $past(ctrl2_o[4:2]) && ctrl2_o[7:5] == $past(ctrl2_wdata_i[7:5]))
    else $error("control bits not locked");
  a_disable_clears: assert property (!port_enable_i |=> !start_seen_o && !stop_seen_o && scl_oe_n_o && sda_oe_n_o)
    else $error("disable left state behind");
  a_bus_free: assert property (bus_free_o == (stop_seen_o || !start_seen_o))
    else $error("bus free wrong");
  a_wake_cause: assert property (wake_o |-> $past(sleep_i) && $past(irq_enable_i) && port_irq_o)
    else $error("wake without cause");
  a_wake_pulse: assert property (wake_o |=> !wake_o)
    else $error("wake longer than a cycle");
  a_coll_release: assert property ($rose(bus_coll_o) |-> ctrl2_o[1:0] == 2'b00 && scl_oe_n_o && sda_oe_n_o)
    else $error("collision did not abort");
  a_rs_ignored: assert property (ctrl2_wr_i && ctrl2_wdata_i[1] && ctrl2_o[0] |=> !ctrl2_o[1])
    else $error("restart taken while busy");
  a_xfer_irq: assert property (xfer_event_i && port_enable_i && mode_select_i == MODE_MASTER |=> port_irq_o)
    else $error("no irq on transfer event");
  a_start_seen: assert property ($fell(sda_oe_n_o) && ctrl2_o[0] |-> ##[1:6] start_seen_o)
    else $error("start not seen");
endmodule : isb_core_checker
bind isb_core isb_core_checker #(.DW(DW)) u_chk (.*);

// *** tb/isb_bus_model.sv ***
// far-side bus party: sends one-byte frames and can clamp both lines low
`timescale 1ns/1ps
module isb_bus_model (
  input wire logic scl_i, // resolved scl
  input wire logic jam_i, // clamp both lines low
  output logic scl_pull_o, // pulls scl low
  output logic sda_pull_o // pulls sda low
);
  logic scl_drv_r, sda_drv_r;
  assign scl_pull_o = scl_drv_r | jam_i;
  assign sda_pull_o = sda_drv_r | jam_i;
  initial begin
    scl_drv_r = 1'b0;
    sda_drv_r = 1'b0;
  end
  // 160 ns scl; honours stretching, so a full receiver stalls the frame
  task automatic send_byte(input logic [7:0] b);
    sda_drv_r = 1'b1;
    #80 scl_drv_r = 1'b1;
    for (int i = 8; i >= 0; i--) begin
      #40 sda_drv_r = (i > 0) ? ~b[i-1] : 1'b0;
      #40 scl_drv_r = 1'b0;
      // let the wired line settle, then a bounded wait for a stretcher
      #0;
      for (int k = 0; k < 4000 && scl_i !== 1'b1; k++) #1;
      #80 scl_drv_r = 1'b1;
    end
    #40 sda_drv_r = 1'b1;
    #40 scl_drv_r = 1'b0;
    #80 sda_drv_r = 1'b0;
    #80;
  endtask : send_byte
endmodule : isb_bus_model

// *** tb/isb_core_tb_top.sv ***
// self-checking bench for the start, restart, baud and general call block
`timescale 1ns/1ps
module isb_core_tb_top;
  import isb_pkg::*;
  localparam int T = 2 * (3 + 1);
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, port_enable_i = 1'b0, ten_bit_i = 1'b0;
  logic ctrl2_wr_i = 1'b0, buf_wr_i = 1'b0, buf_rd_i = 1'b0, ua_clr_i = 1'b0;
  logic xfer_event_i = 1'b0, irq_clr_i = 1'b0, bcl_clr_i = 1'b0, write_collision_flag_clr_i = 1'b0;
  logic sleep_i = 1'b0, irq_enable_i = 1'b0, rx_ready_i = 1'b0, jam = 1'b0;
  logic [3:0] mode_select_i = MODE_MASTER;
  logic [7:0] address_baud_i = 8'h03, ctrl2_wdata_i = 8'h00, buf_wdata_i = 8'h00;
  logic scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, buffer_full_o, update_address_o;
  logic port_irq_o, bus_coll_o, write_coll_o, start_seen_o, stop_seen_o, bus_free_o;
  logic wake_o, rx_valid_o, scl_pull, sda_pull, st_b, rs_b;
  logic [7:0] ctrl2_o, buffer_o, rx_data_o;
  int mismatches = 0, total_checks = 0, wakes = 0, n;
  wire scl = !(!scl_oe_n_o || scl_pull);
  wire sda = !(!sda_oe_n_o || sda_pull);
  assign st_b = ctrl2_o[0];
  assign rs_b = ctrl2_o[1];
  isb_core uut (.scl_i(scl), .sda_i(sda), .*);
  isb_bus_model bm (.scl_i(scl), .jam_i(jam), .scl_pull_o(scl_pull), .sda_pull_o(sda_pull));
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (wake_o === 1'b1) wakes++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_i);
  endtask : cyc
  // samples 1 ns after the edge so the design's updates have landed
  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    #1;
    while (s !== v && n < 5000) begin
      @(posedge mclk_i);
      #1 n++;
    end
    if (n == 5000) begin
      mismatches++;
      results();
    end
  endtask : wait_for
  task automatic wr2(input logic [7:0] d);
    @(posedge mclk_i);
    ctrl2_wdata_i <= d;
    ctrl2_wr_i <= 1'b1;
    @(posedge mclk_i);
    ctrl2_wr_i <= 1'b0;
  endtask : wr2
  task automatic clr_flags();
    @(posedge mclk_i);
    irq_clr_i <= 1'b1;
    write_collision_flag_clr_i <= 1'b1;
    @(posedge mclk_i);
    irq_clr_i <= 1'b0;
    write_collision_flag_clr_i <= 1'b0;
  endtask : clr_flags
  task automatic pop(input logic [7:0] d);
    wait_for(rx_valid_o, 1'b1);
    chk(rx_data_o, d);
    @(posedge mclk_i);
    rx_ready_i <= 1'b1;
    buf_rd_i <= 1'b1;
    @(posedge mclk_i);
    rx_ready_i <= 1'b0;
    buf_rd_i <= 1'b0;
  endtask : pop
  task automatic t_start();
    wr2(8'h01);
    @(posedge mclk_i);
    buf_wdata_i <= 8'h5A;
    buf_wr_i <= 1'b1;
    @(posedge mclk_i);
    buf_wr_i <= 1'b0;
    wr2(8'h07);
    wait_for(sda_oe_n_o, 1'b0);
    chk({write_coll_o, buffer_o}, {1'b1, BUF_RST});
    chk(ctrl2_o[2:1], 2'b00);
    chk({scl_o, sda_o, sda}, 3'b000);
    wait_for(st_b, 1'b0);
    chk(n, T);
    chk({port_irq_o, sda_oe_n_o, start_seen_o, bus_free_o}, 4'b1010);
  endtask : t_start
  task automatic t_restart();
    clr_flags();
    wr2(8'h02);
    wr2(8'h03);
    chk(scl_oe_n_o, 1'b0);
    wait_for(rs_b, 1'b0);
    chk({port_irq_o, scl_oe_n_o, sda_oe_n_o}, 3'b100);
    chk({ctrl2_o[0], bus_coll_o}, 2'b00);
  endtask : t_restart
  task automatic t_coll();
    @(posedge mclk_i);
    port_enable_i <= 1'b0;
    cyc(2);
    chk({start_seen_o, stop_seen_o, scl_oe_n_o, sda_oe_n_o, ctrl2_o[1:0]}, 6'b001100);
    port_enable_i <= 1'b1;
    jam <= 1'b1;
    cyc(4);
    wr2(8'h01);
    wait_for(bus_coll_o, 1'b1);
    chk({ctrl2_o[0], scl_oe_n_o, sda_oe_n_o}, 3'b011);
    @(posedge mclk_i);
    jam <= 1'b0;
    bcl_clr_i <= 1'b1;
    cyc(1);
    bcl_clr_i <= 1'b0;
  endtask : t_coll
  task automatic t_xfer();
    clr_flags();
    xfer_event_i <= 1'b1;
    @(posedge mclk_i);
    xfer_event_i <= 1'b0;
    cyc(1);
    chk(port_irq_o, 1'b1);
  endtask : t_xfer
  task automatic t_slave();
    int w;
    @(posedge mclk_i);
    mode_select_i <= 4'h0;
    address_baud_i <= 8'hA4;
    ten_bit_i <= 1'b1;
    sleep_i <= 1'b1;
    irq_enable_i <= 1'b1;
    cyc(4);
    bm.send_byte(8'h00);
    cyc(4);
    chk({rx_valid_o, buffer_full_o}, 2'b00);
    chk({stop_seen_o, bus_free_o}, 2'b11);
    wr2(8'h80);
    clr_flags();
    w = wakes;
    bm.send_byte(GC_ADDR);
    cyc(4);
    chk({buffer_o, buffer_full_o, port_irq_o, update_address_o}, {GC_ADDR, 3'b110});
    chk(wakes, w + 1);
    bm.send_byte(8'hA5);
    fork
      bm.send_byte(8'hA4);
      begin
        cyc(150);
        chk(scl, 1'b0);
        pop(GC_ADDR);
        pop(8'hA5);
      end
    join
    pop(8'hA4);
    cyc(2);
    chk(rx_valid_o, 1'b0);
  endtask : t_slave
  initial begin
    cyc(6);
    sys_rst_i <= 1'b0;
    cyc(3);
    chk({ctrl2_o, port_irq_o, bus_coll_o, write_coll_o, start_seen_o}, {CTRL2_RST, 4'h0});
    port_enable_i <= 1'b1;
    cyc(1);
    t_start();
    t_restart();
    t_coll();
    t_xfer();
    t_slave();
    results();
  end
  // guard against a bus partner left waiting on a held clock line
  initial begin
    #1000000;
    mismatches++;
    results();
  end
endmodule : isb_core_tb_top
